/* ram_port_pkg.sv */
// Constants, register map and types shared by the embedded RAM port wrapper
package ram_port_pkg;

	// ==========================================================================
	// Array geometry defaults
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int NUM_PORTS = 2;

	// ==========================================================================
	// APB register map
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] CTRL_OFS   = 12'h000;
	localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;

	// Control field positions
	localparam int CTRL_OUT_REG_BIT = 0;
	localparam int CTRL_FLOW_BIT    = 1;
	localparam int CTRL_SPLIT_BIT   = 2;
	localparam int CTRL_W           = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

	// Status field positions
	localparam int STAT_FLOW_ACT_BIT = 0;
	localparam int STAT_IN_CLR_BIT   = 1;
	localparam int STAT_OUT_CLR_BIT  = 2;
	localparam int STAT_SPLIT_BIT    = 3;
	localparam int STAT_KIND_LSB     = 4;

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;

	// Physical block size class
	typedef enum logic [1:0] {KIND_SMALL, KIND_MID, KIND_LARGE} block_kind_t;

endpackage : ram_port_pkg

/* ram_core_if.sv */
// Connection between the port register logic and the RAM array core
`timescale 1ns/100ps
interface ram_core_if #(
	parameter int AW = 9,
	parameter int DW = 8
);
	logic          write_strobe [2];	// Self-timed write per port
	logic [AW-1:0] wr_addr      [2];	// Registered write address
	logic [DW-1:0] wr_data      [2];	// Registered write data
	logic          rd_en_d      [2];	// Read enable about to be registered
	logic [AW-1:0] rd_addr_d    [2];	// Read address about to be registered
	logic          fl_en_d;			// Flow-through read enable, falling edge
	logic [AW-1:0] fl_addr_d;		// Flow-through address, falling edge
	logic [DW-1:0] arr_q        [2];	// Array read data, rising-edge path
	logic [DW-1:0] fl_q;			// Array read data, flow-through path

	modport ctl  (output write_strobe, wr_addr, wr_data, rd_en_d, rd_addr_d, fl_en_d, fl_addr_d, input arr_q, fl_q);
	modport core (input write_strobe, wr_addr, wr_data, rd_en_d, rd_addr_d, fl_en_d, fl_addr_d, output arr_q, fl_q);
endinterface : ram_core_if

/* ram_array_core.sv */
// RAM array with registered read paths on both clock edges
`timescale 1ns/100ps
module ram_array_core #(
	parameter int AW = 9,
	parameter int DW = 8
)(
	input  wire logic ref_clk,	// Port clock
	input  wire logic rstn,		// Asynchronous reset, active low
	ram_core_if.core  bus		// Port logic side
);
	import ram_port_pkg::*;

	logic [DW-1:0] mem [2**AW];
	logic [AW-1:0] fl_addr;

	// ==========================================================================
	// Write: strobe from the registered inputs, timed by the clock itself
	always_ff @(posedge ref_clk)
	begin
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (bus.write_strobe[p])
				mem[bus.wr_addr[p]] <= bus.wr_data[p];
		end
	end

	// ==========================================================================
	// Rising-edge read; not touched by the input clear so data holds
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_rd
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
				bus.arr_q[p] <= '0;
			else if (bus.rd_en_d[p])
				bus.arr_q[p] <= mem[bus.rd_addr_d[p]];
		end
	end

	// ==========================================================================
	// Falling-edge read address so data is valid in the same cycle; held while the read enable is low
	always_ff @(negedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			fl_addr <= '0;
		else if (bus.fl_en_d)
			fl_addr <= bus.fl_addr_d;
	end

	assign bus.fl_q = mem[fl_addr];

endmodule : ram_array_core

/* ram_port_regs.sv */
// Port registers, output pipeline and APB control around the RAM array
`timescale 1ns/100ps
// How it works
// - Address, data and write control of both ports are registered on the port clock.
// - The array writes from its own clock-timed strobe; fabric shapes no pulse.
// - Pipelined use registers both the inputs and the read outputs.
// - Output registers are optional; bypassed, read data comes straight from the array.
// - Flow-through only in simple dual-port mode and never on the large block.
// - Flow-through registers read enable and address on the falling edge, port B output bypassed.
// - Split mode gives each port its own half of a mid-size block.
// - The input clear resets the input registers at once, without a clock.
// - After an input clear the read data holds until the next clock edge.
// - The output clear resets the output registers and shows immediately on outputs that are not bypassed.
module ram_port_regs #(
	parameter int                        AW   = ram_port_pkg::ADDR_W,	// Address width
	parameter int                        DW   = ram_port_pkg::DATA_W,	// Data width
	parameter ram_port_pkg::block_kind_t KIND = ram_port_pkg::KIND_MID	// Block size class
)(
	input  wire logic                           ref_clk,	// Port clock, 25 MHz
	input  wire logic                           rstn,		// Asynchronous reset, active low
	input  wire logic [ram_port_pkg::APB_AW-1:0] paddr,	// APB address
	input  wire logic                           psel,		// APB select
	input  wire logic                           penable,	// APB enable
	input  wire logic                           pwrite,		// APB direction
	input  wire logic [31:0]                    pwdata,		// APB write data
	output logic      [31:0]                    prdata,		// APB read data
	output logic                                pready,		// APB ready
	output logic                                pslverr,	// APB error
	input  wire logic                           in_clr_n,	// Input register clear, active low
	input  wire logic                           out_clr_n,	// Output register clear, active low
	input  wire logic                           a_en,		// Port A enable
	input  wire logic                           a_we,		// Port A write
	input  wire logic [AW-1:0]                  a_addr,		// Port A address
	input  wire logic [DW-1:0]                  a_wdata,	// Port A write data
	output logic      [DW-1:0]                  a_q,		// Port A read data
	input  wire logic                           b_en,		// Port B enable
	input  wire logic                           b_we,		// Port B write
	input  wire logic [AW-1:0]                  b_addr,		// Port B address
	input  wire logic [DW-1:0]                  b_wdata,	// Port B write data
	output logic      [DW-1:0]                  b_q			// Port B read data
);
	import ram_port_pkg::*;

	// ==========================================================================
	// Declarations
	logic [CTRL_W-1:0] ctrl;
	logic              in_rstn;
	logic              out_rstn;
	logic              out_reg_on;
	logic              flow_req;
	logic              split;
	logic              flow_act;
	logic              in_clr_q [SYNC_STAGES];
	logic              out_clr_q [SYNC_STAGES];
	logic              in_clr_seen;
	logic              out_clr_seen;
	logic              apb_wr;
	logic              apb_rd;
	logic              hit_ctrl;
	logic              hit_stat;
	logic [31:0]       stat_word;
	logic              en_pin   [2];
	logic              we_pin   [2];
	logic [AW-1:0]     addr_pin [2];
	logic [DW-1:0]     data_pin [2];
	logic [AW-1:0]     addr_eff [2];
	logic              en_q     [2];
	logic              we_q     [2];
	logic [AW-1:0]     addr_q   [2];
	logic [DW-1:0]     data_q   [2];
	logic [DW-1:0]     raw_q    [2];
	logic [DW-1:0]     out_q    [2];
	logic [DW-1:0]     port_q   [2];

	ram_core_if #(.AW(AW), .DW(DW)) core_bus ();

	ram_array_core #(
		.AW (AW),
		.DW (DW)
	) u_core (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.bus     (core_bus)
	);

	// ==========================================================================
	// Clear domains: each pin clear joins the global reset asynchronously
	assign in_rstn  = rstn & in_clr_n;
	assign out_rstn = rstn & out_clr_n;

	// ==========================================================================
	// Mode decode; flow-through is refused on the large block and in split mode
	assign out_reg_on = ctrl[CTRL_OUT_REG_BIT];
	assign flow_req   = ctrl[CTRL_FLOW_BIT];
	assign split      = ctrl[CTRL_SPLIT_BIT] && (KIND == KIND_MID);
	assign flow_act   = flow_req && !split && (KIND != KIND_LARGE);

	// ==========================================================================
	// Pin view gathered per port
	assign en_pin[0]   = a_en;
	assign we_pin[0]   = a_we;
	assign addr_pin[0] = a_addr;
	assign data_pin[0] = a_wdata;
	assign en_pin[1]   = b_en;
	assign we_pin[1]   = b_we;
	assign addr_pin[1] = b_addr;
	assign data_pin[1] = b_wdata;

	// ==========================================================================
	// Per-port input registers, write strobe and output pipeline
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		// Split mode pins the top address bit to the port number
		assign addr_eff[p] = split ? {1'(p), addr_pin[p][AW-2:0]} : addr_pin[p];

		// Input registers, cleared at once by the input clear
		always_ff @(posedge ref_clk or negedge in_rstn)
		begin
			if (!in_rstn)
			begin
				en_q[p]   <= 1'b0;
				we_q[p]   <= 1'b0;
				addr_q[p] <= '0;
				data_q[p] <= '0;
			end
			else
			begin
				en_q[p]   <= en_pin[p];
				we_q[p]   <= we_pin[p];
				addr_q[p] <= addr_eff[p];
				data_q[p] <= data_pin[p];
			end
		end

		// Strobe from registered controls only; fabric gives a level
		assign core_bus.write_strobe[p] = en_q[p] & we_q[p];
		assign core_bus.wr_addr[p]      = addr_q[p];
		assign core_bus.wr_data[p]      = data_q[p];

		// Read path sees the cleared inputs, but only from the next edge
		assign core_bus.rd_en_d[p]   = in_rstn ? en_pin[p] : 1'b1;
		assign core_bus.rd_addr_d[p] = in_rstn ? addr_eff[p] : {AW{1'b0}};

		// Port B carries the flow-through read
		assign raw_q[p] = (p == 1 && flow_act) ? core_bus.fl_q : core_bus.arr_q[p];

		// Output registers, cleared at once by the output clear
		always_ff @(posedge ref_clk or negedge out_rstn)
		begin
			if (!out_rstn)
				out_q[p] <= '0;
			else
				out_q[p] <= raw_q[p];
		end

		// Bypass when disabled, or on port B when flow-through is running
		assign port_q[p] = (out_reg_on && !(p == 1 && flow_act)) ? out_q[p] : raw_q[p];
	end

	assign a_q = port_q[0];
	assign b_q = port_q[1];

	// ==========================================================================
	// Flow-through address follows the clear rule as the other read paths
	assign core_bus.fl_en_d   = in_rstn ? en_pin[1] : 1'b1;
	assign core_bus.fl_addr_d = in_rstn ? addr_eff[1] : {AW{1'b0}};

	// ==========================================================================
	// Clear pin synchronisers for status only; the clears act asynchronously
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < SYNC_STAGES; i++)
			begin
				in_clr_q[i]  <= 1'b0;
				out_clr_q[i] <= 1'b0;
			end
		end
		else
		begin
			in_clr_q[0]  <= ~in_clr_n;
			out_clr_q[0] <= ~out_clr_n;
			for (int i = 1; i < SYNC_STAGES; i++)
			begin
				in_clr_q[i]  <= in_clr_q[i-1];
				out_clr_q[i] <= out_clr_q[i-1];
			end
		end
	end

	// Level changes only once the last two stages agree
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			in_clr_seen  <= 1'b0;
			out_clr_seen <= 1'b0;
		end
		else
		begin
			if (in_clr_q[1] == in_clr_q[2])
				in_clr_seen <= in_clr_q[2];
			if (out_clr_q[1] == out_clr_q[2])
				out_clr_seen <= out_clr_q[2];
		end
	end

	// ==========================================================================
	// APB slave: zero wait states, error on unmapped addresses
	assign apb_wr   = psel & penable & pwrite;
	assign apb_rd   = psel & penable & ~pwrite;
	assign hit_ctrl = (paddr == CTRL_OFS);
	assign hit_stat = (paddr == STATUS_OFS);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~(hit_ctrl | (hit_stat & ~pwrite));

	// Status word assembled from live state
	always_comb
	begin
		stat_word = '0;
		stat_word[STAT_FLOW_ACT_BIT] = flow_act;
		stat_word[STAT_IN_CLR_BIT]   = in_clr_seen;
		stat_word[STAT_OUT_CLR_BIT]  = out_clr_seen;
		stat_word[STAT_SPLIT_BIT]    = split;
		stat_word[STAT_KIND_LSB +: 2] = KIND;
	end

	// Control register; changes only between memory operations by convention
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			ctrl <= CTRL_RESET;
		else if (apb_wr && hit_ctrl)
			ctrl <= pwdata[CTRL_W-1:0];
	end

	// Read data registered in the setup phase, valid in the access phase
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl} : (hit_stat ? stat_word : 32'h0000_0000);
	end

endmodule : ram_port_regs

/* ram_port_chk_assertions.sv */
// Pin-level checker for the RAM port wrapper
`timescale 1ns/100ps
// ==========
// Checker
module ram_port_chk #(
	parameter int DW = 8
)(
	input wire logic                            ref_clk,	// Port clock
	input wire logic                            rstn,	// Reset, active low
	input wire logic [ram_port_pkg::APB_AW-1:0] paddr,	// APB address
	input wire logic                            psel,	// APB select
	input wire logic                            penable,	// APB enable
	input wire logic                            pwrite,	// APB direction
	input wire logic [31:0]                     pwdata,	// APB write data
	input wire logic                            in_clr_n,	// Input clear
	input wire logic                            out_clr_n,	// Output clear
	input wire logic                            a_en,	// Port A enable
	input wire logic                            b_en,	// Port B enable
	input wire logic [DW-1:0]                   a_q,	// Port A data
	input wire logic [DW-1:0]                   b_q	// Port B data
);
	import ram_port_pkg::*;
	logic [2:0] ctrl;	// CTRL shadow
	wire        flow = ctrl[1] & ~ctrl[2];	// Flow mode on port B
	// Shadow follows APB writes, since the pins hide the mux setting
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			ctrl <= 3'h0;
		else if (psel && penable && pwrite && paddr == CTRL_OFS)
			ctrl <= pwdata[2:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	chk_a_idle_hold:
	assert property (!ctrl[0] && !$past(ctrl[0]) && $past(in_clr_n) && !$past(a_en) |-> $stable(a_q)) else $error("a_q moved");
	chk_b_idle_hold:
	assert property (!ctrl[0] && !$past(ctrl[0]) && !flow && !$past(flow) && $past(in_clr_n) && !$past(b_en)
		|-> $stable(b_q)) else $error("b_q moved");
	chk_a_pipe_lag:
	assert property (ctrl[0] && $past(ctrl[0]) && $past(ctrl[0], 2) && out_clr_n && $past(out_clr_n)
		&& $past(out_clr_n, 2) && $past(in_clr_n, 2) && !$past(a_en, 2) |-> $stable(a_q)) else $error("a_q pipe early");
	chk_b_pipe_lag:
	assert property (ctrl[0] && $past(ctrl[0]) && $past(ctrl[0], 2) && !flow && out_clr_n && $past(out_clr_n)
		&& $past(out_clr_n, 2) && $past(in_clr_n, 2) && !$past(b_en, 2) |-> $stable(b_q)) else $error("b_q pipe early");
	chk_out_clear_zero:
	assert property (!out_clr_n && ctrl[0] && !flow |-> a_q == '0 && b_q == '0) else $error("out clear not seen");
	chk_in_clear_a:
	assert property (!in_clr_n [*4] |-> $stable(a_q)) else $error("a_q moved in clear");
	chk_in_clear_b:
	assert property (!flow && !in_clr_n [*4] |-> $stable(b_q)) else $error("b_q moved in clear");
	chk_flow_idle_hold:
	assert property (flow && $past(flow) && in_clr_n && $past(in_clr_n) && !b_en
		&& !$past(a_en, 2) && !$past(b_en, 2) |-> $stable(b_q)) else $error("flow b_q moved");
endmodule : ram_port_chk
bind ram_port_regs ram_port_chk #(
	.DW (DW)
) u_chk (
	.ref_clk   (ref_clk),
	.rstn      (rstn),
	.paddr     (paddr),
	.psel      (psel),
	.penable   (penable),
	.pwrite    (pwrite),
	.pwdata    (pwdata),
	.in_clr_n  (in_clr_n),
	.out_clr_n (out_clr_n),
	.a_en      (a_en),
	.b_en      (b_en),
	.a_q       (a_q),
	.b_q       (b_q)
);

/* ram_fabric_model.sv */
// Fabric-side model driving both RAM ports
`timescale 1ns/100ps
// ==========
// Fabric model
module ram_fabric_model (
	input  wire logic                      ref_clk,	// Port clock
	output logic                           a_en,	// Port A enable
	output logic                           a_we,	// Port A write
	output logic [ram_port_pkg::ADDR_W-1:0] a_addr,	// Port A address
	output logic [ram_port_pkg::DATA_W-1:0] a_wdata,	// Port A data
	output logic                           b_en,	// Port B enable
	output logic                           b_we,	// Port B write
	output logic [ram_port_pkg::ADDR_W-1:0] b_addr,	// Port B address
	output logic [ram_port_pkg::DATA_W-1:0] b_wdata	// Port B data
);
	import ram_port_pkg::*;
	// Idle at time zero
	initial
	begin
		{a_en, a_we, a_addr, a_wdata} = '0;
		{b_en, b_we, b_addr, b_wdata} = '0;
	end
	// One op: present after an edge, hold over the capture edge
	task automatic op(input logic p, input logic we, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		if (p)
			{b_en, b_we, b_addr, b_wdata} <= {1'b1, we, ad, d};
		else
			{a_en, a_we, a_addr, a_wdata} <= {1'b1, we, ad, d};
		@(posedge ref_clk);
		{a_en, b_en} <= 2'h0;
		// Flip released lines so stale values never look held
		if (p)
			{b_addr, b_wdata} <= ~{ad, d};
		else
			{a_addr, a_wdata} <= ~{ad, d};
	endtask : op
endmodule : ram_fabric_model

/* ram_port_regs_tb.sv */
// Self-checking bench for the RAM port wrapper
`timescale 1ns/100ps
// ==========
// Bench
module ram_port_regs_tb;
	import ram_port_pkg::*;
	logic              ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic              in_clr_n = 1'b1, out_clr_n = 1'b1, pready, pslverr, er;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rd;
	logic              a_en, a_we, b_en, b_we;
	logic [ADDR_W-1:0] a_addr, b_addr;
	logic [DATA_W-1:0] a_wdata, b_wdata, a_q, b_q;
	int                fails = 0, cmp_count = 0;
	ram_port_regs u_dut (.*);
	ram_fabric_model u_fab (.*);
	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;
	// Compare and count
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		fails += (got !== exp);
		if (got !== exp)
			$display("Error %s expected %h seen %h", nm, exp, got);
	endtask : check
	// APB transfer; waits on pready, bounded by the watchdog
	task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge ref_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// ==========
	// Scenarios
	task automatic t_regs;
		apb(1'b0, CTRL_OFS, 32'h0, rd, er);
		check("ctrl_reset", rd, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h5, rd, er);
		apb(1'b0, STATUS_OFS, 32'h0, rd, er);
		check("status_split", rd, 32'h18);
		apb(1'b0, 12'h008, 32'h0, rd, er);
		check("unmapped", {rd[30:0], er}, 32'h1);
		apb(1'b1, STATUS_OFS, 32'h0, rd, er);
		check("status_ro", er, 32'h1);
		#1 check("bus_idle", {pready, pslverr}, 32'h2);
		apb(1'b1, CTRL_OFS, 32'h0, rd, er);
		$display("t_regs done");
	endtask : t_regs
	// Writes on both ports, one idle cycle apart, then reads with bypassed outputs
	task automatic t_rw;
		u_fab.op(1'b0, 1'b1, 9'h000, 8'h77);
		u_fab.op(1'b0, 1'b1, 9'h003, 8'ha5);
		u_fab.op(1'b1, 1'b1, 9'h004, 8'h3c);
		u_fab.op(1'b0, 1'b1, 9'h005, 8'h66);
		u_fab.op(1'b0, 1'b0, 9'h003, 8'h00);
		#1 check("a_read", a_q, 32'ha5);
		u_fab.op(1'b1, 1'b0, 9'h004, 8'h00);
		#1 check("b_read", b_q, 32'h3c);
		$display("t_rw done");
	endtask : t_rw
	// Output registers add one edge
	task automatic t_pipe;
		apb(1'b1, CTRL_OFS, 32'h1, rd, er);
		u_fab.op(1'b0, 1'b0, 9'h003, 8'h00);
		u_fab.op(1'b0, 1'b0, 9'h004, 8'h00);
		#1 check("pipe_early", a_q, 32'ha5);
		@(posedge ref_clk);
		#1 check("pipe_late", a_q, 32'h3c);
		$display("t_pipe done");
	endtask : t_pipe
	// Output clear, input clear, and a write aborted by the input clear
	task automatic t_clear;
		@(posedge ref_clk);
		out_clr_n <= 1'b0;
		#1 check("out_clear", a_q, 32'h0);
		@(posedge ref_clk);
		out_clr_n <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h0, rd, er);
		u_fab.op(1'b0, 1'b0, 9'h003, 8'h00);
		in_clr_n <= 1'b0;
		#1 check("in_clear_hold", a_q, 32'ha5);
		@(posedge ref_clk);
		#1 check("in_clear_edge", a_q, 32'h77);
		repeat (2) @(posedge ref_clk);
		apb(1'b0, STATUS_OFS, 32'h0, rd, er);
		check("in_clear_status", rd, 32'h12);
		in_clr_n <= 1'b1;
		u_fab.op(1'b0, 1'b1, 9'h005, 8'hee);
		in_clr_n <= 1'b0;
		@(posedge ref_clk);
		in_clr_n <= 1'b1;
		u_fab.op(1'b0, 1'b0, 9'h005, 8'h00);
		#1 check("write_aborted", a_q, 32'h66);
		$display("t_clear done");
	endtask : t_clear
	// Flow-through read lands before the next rising edge
	task automatic t_flow;
		apb(1'b1, CTRL_OFS, 32'h2, rd, er);
		fork
			u_fab.op(1'b1, 1'b0, 9'h003, 8'h00);
			begin
				@(posedge ref_clk);
				@(negedge ref_clk);
				#1 check("flow_same_cycle", b_q, 32'ha5);
			end
		join
		apb(1'b0, STATUS_OFS, 32'h0, rd, er);
		check("flow_active", rd[0], 32'h1);
		$display("t_flow done");
	endtask : t_flow
	// Split halves keep the same address apart; a flow request is refused in split
	task automatic t_split;
		apb(1'b1, CTRL_OFS, 32'h6, rd, er);
		apb(1'b0, STATUS_OFS, 32'h0, rd, er);
		check("split_no_flow", rd, 32'h18);
		u_fab.op(1'b0, 1'b1, 9'h003, 8'h11);
		u_fab.op(1'b1, 1'b1, 9'h003, 8'h22);
		u_fab.op(1'b0, 1'b0, 9'h003, 8'h00);
		#1 check("split_a", a_q, 32'h11);
		u_fab.op(1'b1, 1'b0, 9'h003, 8'h00);
		#1 check("split_b", b_q, 32'h22);
		$display("t_split done");
	endtask : t_split
	// Main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs;
		t_rw;
		t_pipe;
		t_clear;
		t_flow;
		t_split;
		give_verdict;
	end
	// Watchdog, far beyond the hundred or so cycles the tests need
	initial
	begin
		#100000;
		fails++;
		give_verdict;
	end
endmodule : ram_port_regs_tb
